// [common/mio_pkg.sv]
// constants for the port subsystem: port indices, sequencing steps, reset values
package mio_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_SENSE = 6'h00;
  localparam logic [5:0] IDX_OUT_A = 6'h01;
  localparam logic [5:0] IDX_OUT_B = 6'h02;
  localparam logic [5:0] IDX_BIDIR_A = 6'h04;
  localparam logic [5:0] IDX_BIDIR_D = 6'h07;
  localparam logic [5:0] IDX_MULTI = 6'h08;
  localparam logic [5:0] IDX_SERIAL = 6'h09;
  localparam logic [5:0] IDX_HOLD = 6'h0E;
  localparam logic [5:0] IDX_PORT_TOP = 6'h1F;
  localparam logic [5:0] IDX_POINTER = 6'h20;
  localparam logic [5:0] IDX_BIT_OP = 6'h21;
  // bit-op command field positions
  localparam int BIT_SET_POS = 0;
  localparam int BIT_CLR_POS = 1;
  // multifunction pin positions
  localparam int MF_LOW_IRQ = 0;
  localparam int MF_TIMER_B = 1;
  localparam int MF_HIGH_IRQ = 2;
  localparam int MF_TIMER_A = 3;
  // two instruction cycles of four states each
  localparam int STATES_PER_CYCLE = 4;
  localparam logic [2:0] STEP_THIRD_PHASE = 3'(STATES_PER_CYCLE + 2);
  localparam logic [2:0] STEP_FOURTH_PHASE = 3'(STATES_PER_CYCLE + 3);
  // reset values
  localparam logic [3:0] LATCH_RESET = 4'hF;
  localparam logic [3:0] POINTER_RESET = 4'h0;
  // sequencer states
  typedef enum logic {MIO_IDLE, MIO_BUSY} mio_state_t;
endpackage

// [core/mio_port_subsystem.sv]
// port subsystem: i/o port latches, pin sampling and apb access sequencing
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
// Behaviour
// - decode port address 00h..1Fh to one register
// - input sampled in third phase, cycle two
// - output latch updated fourth phase, cycle two
// - input-only ports return live pins, unlatched
// - output ports keep last written value
// - sense port: four input-only bits
// - four 4-bit bidir ports; write one to read
// - reset sets bidir and multifunction latches
// - pointer high bits pick port, low bit
// - multifunction pins feed interrupts and timers
// - high irq pin falling edge always requests; code: only while multi_lat[MF_HIGH_IRQ] is one
// - low irq pin falling edge requests too; code: only while multi_lat[MF_LOW_IRQ] is one
// - 3-bit bidir port shared with serial
// - 1-bit sense input doubles as hold
// - serial port reads missing bit as one
// - serial use needs latch one, enable gated
module mio_port_subsystem
  import mio_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // input-only pins
  input wire logic [3:0] sense_input_port,
  input wire logic hold_sense_input,
  // output-only pins
  output logic [3:0] output_port_a,
  output logic [3:0] output_port_b,
  // bidir ports a..d, open drain, four bits each
  input wire logic [15:0] bidir_in,
  output logic [15:0] bidir_out,
  output logic [15:0] bidir_oe,
  // multifunction port
  input wire logic [3:0] multifunction_port_in,
  output logic [3:0] multifunction_port_out,
  output logic [3:0] multifunction_port_oe,
  // serial shared port
  input wire logic [2:0] serial_shared_port_in,
  output logic [2:0] serial_shared_port_out,
  output logic [2:0] serial_shared_port_oe,
  // serial interface side
  input wire logic serial_enable,
  input wire logic [2:0] serial_drive,
  output logic [2:0] serial_sense,
  // alternate functions toward timers, interrupt and hold logic
  output logic high_priority_ext_irq,
  output logic low_priority_ext_irq,
  output logic [1:0] timer_event_in,
  output logic hold_request
);

  // wired read of an open-drain pin: low latch forces zero
  function automatic logic [3:0] wired_read(input logic [3:0] latch, input logic [3:0] pin);
    wired_read = latch & pin;
  endfunction

  logic [27:0] sync_a; // first synchroniser stage
  logic [27:0] sync_b; // second stage, read by logic
  logic [3:0] sense_s; // synced sense port
  logic [15:0] bidir_s; // synced bidir pins
  logic [3:0] multi_s; // synced multifunction pins
  logic [2:0] serial_s; // synced serial pins
  logic hold_s; // synced hold pin
  logic [3:0] out_a; // output port a latch
  logic [3:0] out_b; // output port b latch
  logic [3:0] bidir_lat [4]; // bidir port latches
  logic [3:0] multi_lat; // multifunction latch
  logic [2:0] serial_lat; // serial port latch
  logic [3:0] pointer; // bit pointer
  mio_state_t state; // sequencer state
  logic [2:0] step; // state count within the two cycles
  logic [5:0] idx; // register index
  logic mapped; // index inside the map
  logic [31:0] next_rdata; // read value at sampling phase
  logic [3:0] bidir_rd [4]; // wired bidir read values
  logic [3:0] multi_rd; // wired multifunction read
  logic [2:0] serial_rd; // wired serial read
  logic ptr_bit; // bit addressed by the pointer
  logic [1:0] irq_prev; // previous levels of irq pins
  logic sample_now; // third phase of second cycle
  logic update_now; // fourth phase of second cycle

  // two flop synchroniser on all pin inputs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= '0;
      sync_b <= '0;
    end else if (clk_en) begin
      sync_a <= {hold_sense_input, serial_shared_port_in, multifunction_port_in,
                 bidir_in, sense_input_port};
      sync_b <= sync_a;
    end
  end

  // slice synced pins
  assign sense_s = sync_b[3:0];
  assign bidir_s = sync_b[19:4];
  assign multi_s = sync_b[23:20];
  assign serial_s = sync_b[26:24];
  assign hold_s = sync_b[27];

  // wired read values of bidir, multifunction and serial pins
  // latch and pin
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bidir_rd[i] = wired_read(bidir_lat[i], bidir_s[4*i +: 4]);
    end
    multi_rd = wired_read(multi_lat, multi_s);
    serial_rd = serial_lat & serial_s;
    ptr_bit = bidir_rd[pointer[3:2]][pointer[1:0]];
  end

  // address decode
  // port space decode
  assign idx = paddr[7:2];
  assign mapped = (paddr[1:0] == 2'b00) && (idx <= IDX_BIT_OP);

  // sequencer: two instruction cycles per access
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= MIO_IDLE;
      step <= '0;
    end else if (clk_en) begin
      case (state)
        MIO_IDLE: begin
          // setup phase starts the instruction
          if (psel && !penable) begin
            state <= MIO_BUSY;
            step <= '0;
          end
        end
        MIO_BUSY: begin
          // finish after the fourth phase of cycle two
          if (step == STEP_FOURTH_PHASE) begin
            state <= MIO_IDLE;
          end
          step <= step + 3'd1;
        end
        default: begin
          state <= MIO_IDLE;
        end
      endcase
    end
  end

  // phase strobes
  assign sample_now = (state == MIO_BUSY) && (step == STEP_THIRD_PHASE) && clk_en;
  assign update_now = (state == MIO_BUSY) && (step == STEP_FOURTH_PHASE) && clk_en;
  assign pready = update_now && psel && penable;
  assign pslverr = pready && !mapped;

  // read multiplexer
  always_comb begin
    next_rdata = '0;
    if (idx == IDX_SENSE) begin
      next_rdata[3:0] = sense_s;
    end else if (idx == IDX_OUT_A) begin
      next_rdata[3:0] = out_a;
    end else if (idx == IDX_OUT_B) begin
      next_rdata[3:0] = out_b;
    end else if (idx >= IDX_BIDIR_A && idx <= IDX_BIDIR_D) begin
      next_rdata[3:0] = bidir_rd[idx[1:0]];
    end else if (idx == IDX_MULTI) begin
      next_rdata[3:0] = multi_rd;
    end else if (idx == IDX_SERIAL) begin
      next_rdata[3:0] = {1'b1, serial_rd};
    end else if (idx == IDX_HOLD) begin
      next_rdata[0] = hold_s;
    end else if (idx == IDX_POINTER) begin
      next_rdata[3:0] = pointer;
    end else if (idx == IDX_BIT_OP) begin
      next_rdata[0] = ptr_bit;
    end else begin
      next_rdata = '0;
    end
  end

  // read data captured at the sampling phase
  // third phase sample
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= '0;
    end else if (sample_now) begin
      prdata <= (mapped && !pwrite) ? next_rdata : '0;
    end
  end

  // output latches written at the update phase
  // fourth phase update
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_a <= LATCH_RESET;
      out_b <= LATCH_RESET;
      multi_lat <= LATCH_RESET;
      serial_lat <= LATCH_RESET[2:0];
      pointer <= POINTER_RESET;
      for (int i = 0; i < 4; i++) begin
        bidir_lat[i] <= LATCH_RESET;
      end
    end else if (update_now && psel && penable && pwrite && mapped) begin
      if (idx == IDX_OUT_A) begin
        out_a <= pwdata[3:0];
      end else if (idx == IDX_OUT_B) begin
        out_b <= pwdata[3:0];
      end else if (idx >= IDX_BIDIR_A && idx <= IDX_BIDIR_D) begin
        bidir_lat[idx[1:0]] <= pwdata[3:0];
      end else if (idx == IDX_MULTI) begin
        multi_lat <= pwdata[3:0];
      end else if (idx == IDX_SERIAL) begin
        serial_lat <= pwdata[2:0];
      end else if (idx == IDX_POINTER) begin
        pointer <= pwdata[3:0];
      end else if (idx == IDX_BIT_OP) begin
        if (pwdata[BIT_SET_POS]) begin
          bidir_lat[pointer[3:2]][pointer[1:0]] <= 1'b1;
        end else if (pwdata[BIT_CLR_POS]) begin
          bidir_lat[pointer[3:2]][pointer[1:0]] <= 1'b0;
        end
      end
    end
  end

  // pin drive: output ports push-pull, others open drain from the latch
  // bidir open drain
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bidir_out[4*i +: 4] = 4'h0;
      bidir_oe[4*i +: 4] = ~bidir_lat[i];
    end
  end
  assign output_port_a = out_a;
  assign output_port_b = out_b;
  assign multifunction_port_out = 4'h0;
  assign multifunction_port_oe = ~multi_lat;
  assign serial_shared_port_out = 3'h0;
  assign serial_shared_port_oe = ~serial_lat | (serial_enable ? ~serial_drive : 3'h0);
  assign serial_sense = serial_rd;

  // alternate functions: timers from the wired pin levels, hold from the synced pin
  // timer inputs shared
  assign timer_event_in = {multi_rd[MF_TIMER_A], multi_rd[MF_TIMER_B]};
  assign hold_request = hold_s;

  // falling edge detection on interrupt pins, one cycle pulses
  // high edge request
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      // synced pins read zero in reset, so start low to avoid a false edge
      irq_prev <= 2'h0;
      high_priority_ext_irq <= 1'b0;
      low_priority_ext_irq <= 1'b0;
    end else if (clk_en) begin
      irq_prev <= {multi_rd[MF_HIGH_IRQ], multi_rd[MF_LOW_IRQ]};
      high_priority_ext_irq <= irq_prev[1] && !multi_rd[MF_HIGH_IRQ];
      low_priority_ext_irq <= irq_prev[0] && !multi_rd[MF_LOW_IRQ];
    end
  end

  // checks on timing and values
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  access_len_a: assert property (
    (state == MIO_IDLE && psel && !penable && clk_en) ##1 clk_en [*8] |-> pready)
    else $error("access did not end after eight steps");
  read_sample_a: assert property (
    (sample_now && mapped && !pwrite) |=> (prdata == $past(next_rdata)))
    else $error("read data not taken at third phase");
  write_update_a: assert property (
    (pready && !pslverr && pwrite && idx == IDX_OUT_A)
    |=> (output_port_a == $past(pwdata[3:0])))
    else $error("output latch not updated at fourth phase");
  latch_hold_a: assert property (
    (!update_now) |=> $stable(out_b) && $stable(multi_lat))
    else $error("latch changed outside an output update");
  bidir_wired_a: assert property (
    (!bidir_lat[0][0]) |-> (bidir_rd[0][0] == 1'b0) && bidir_oe[0])
    else $error("low latch bit not read as zero");
  serial_top_a: assert property (
    (sample_now && mapped && idx == IDX_SERIAL && !pwrite) |=> prdata[3])
    else $error("serial port top bit not one");
  pointer_bit_a: assert property (
    (pready && !pslverr && pwrite && idx == IDX_BIT_OP && pwdata[BIT_CLR_POS]
     && !pwdata[BIT_SET_POS])
    |=> !bidir_lat[$past(pointer[3:2])][$past(pointer[1:0])])
    else $error("pointer clear missed its bit");
  high_edge_a: assert property (
    (clk_en && irq_prev[1] && !multi_rd[MF_HIGH_IRQ]) |=> high_priority_ext_irq)
    else $error("high priority edge not flagged");
  low_edge_a: assert property (
    (clk_en && irq_prev[0] && !multi_rd[MF_LOW_IRQ]) |=> low_priority_ext_irq)
    else $error("low priority edge not flagged");
  unmapped_a: assert property (
    (pready && idx > IDX_BIT_OP) |-> pslverr)
    else $error("unmapped access not flagged");

endmodule

// [tb/mio_pin_model.sv]
// open-drain pin model: far-side drivers wired with the port drive
`timescale 1ns/1ps
module mio_pin_model (
  // drive enables from the block, one where it pulls low
  input wire logic [22:0] oe,
  // far-side levels, one where it lets the pull-up win
  input wire logic [22:0] ext,
  // resolved pin levels
  output logic [22:0] lvl
);
  // far side drives only released pins
  assign lvl = ext & ~oe;
endmodule

// [tb/testbench.sv]
// self-checking bench for the port subsystem
`timescale 1ns/1ps
module testbench;
  import mio_pkg::*;
  // clock, reset, apb
  logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, hi_irq, lo_irq, hold_request, hold_sense_input = 1;
  // pins and serial side
  logic [3:0] sense_input_port = 4'h0, out_a, out_b;
  logic [22:0] ext = '1, oe, lvl, pout;
  logic serial_enable = 0;
  logic [2:0] serial_drive = 3'h0, serial_sense;
  logic [1:0] timer_event_in;
  int err_count = 0, n_checks = 0, cyc = 0, hits = 0;
  logic [3:0] lat [0:15];
  mio_port_subsystem mio_port_subsystem_i (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense_input_port(sense_input_port), .hold_sense_input(hold_sense_input),
    .output_port_a(out_a), .output_port_b(out_b), .bidir_in(lvl[15:0]),
    .bidir_out(pout[15:0]), .bidir_oe(oe[15:0]), .multifunction_port_in(lvl[19:16]),
    .multifunction_port_out(pout[19:16]), .multifunction_port_oe(oe[19:16]),
    .serial_shared_port_in(lvl[22:20]), .serial_shared_port_out(pout[22:20]),
    .serial_shared_port_oe(oe[22:20]),
    .serial_enable(serial_enable), .serial_drive(serial_drive), .serial_sense(serial_sense),
    .high_priority_ext_irq(hi_irq), .low_priority_ext_irq(lo_irq),
    .timer_event_in(timer_event_in), .hold_request(hold_request));
  mio_pin_model mio_pin_model_i (.oe(oe), .ext(ext), .lvl(lvl));
  always #10 sys_clk = ~sys_clk;
  // count irq pulses, cut a hang short
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    hits <= hits + hi_irq + 100 * lo_irq;
    if (cyc == 8000) begin
      err_count++;
      give_verdict();
    end
  end
  // compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // report and stop
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // sample the answer at the rising edge itself, values before the edge's updates
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 60);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 60) chk("pready", 1, 0);
  endtask
  task automatic rdchk(input string what, input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk(what, exp, rd);
  endtask
  // bench model of a port read
  function automatic logic [31:0] model(input int k);
    case (k)
      0: return sense_input_port;
      1, 2: return lat[k];
      4, 5, 6, 7, 8: return lat[k] & 4'(ext >> (4 * (k - 4)));
      9: return 8 | (lat[9] & ext[22:20]);
      14: return hold_sense_input;
      default: return 0;
    endcase
  endfunction
  // read every port, compare pins
  task automatic check_all();
    int ks [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 14, 31};
    repeat (3) @(posedge sys_clk);
    foreach (ks[j]) rdchk("port", 6'(ks[j]), model(ks[j]));
    chk("out pins", {lat[2], lat[1]}, {out_b, out_a});
    chk("oe", 23'(~{lat[9][2:0], lat[8], lat[7], lat[6], lat[5], lat[4]}), oe);
    chk("pin drive", 0, pout);
    chk("ssense", lat[9][2:0] & ext[22:20], serial_sense);
    chk("hold", hold_sense_input, hold_request);
    chk("timer", {lvl[19], lvl[17]}, timer_event_in);
  endtask
  // main sequence
  initial begin
    logic [3:0] v;
    int h0;
    v = 4'($urandom(95476));
    foreach (lat[k]) lat[k] = (k == 9) ? 4'h7 : 4'hF;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    check_all();
    chk("reset irq", 0, hits);
    repeat (5) begin
      for (int k = 0; k < 10; k++) begin
        v = 4'($urandom);
        apb(1'b1, 6'(k), {28'h000_0000, v});
        if (k != 0 && k != 3) lat[k] = (k == 9) ? v & 4'h7 : v;
      end
      ext <= 23'($urandom);
      sense_input_port <= 4'($urandom);
      hold_sense_input <= 1'($urandom);
      check_all();
    end
    ext <= '1;
    for (int p = 0; p < 16; p++) begin
      v = 4'($urandom);
      apb(1'b1, IDX_POINTER, p);
      apb(1'b1, IDX_BIT_OP, {30'h0, ~v[0], v[0]});
      lat[4 + p / 4][p % 4] = v[0];
      rdchk("pointer", IDX_POINTER, p);
      rdchk("bitop", IDX_BIT_OP, v[0]);
      chk("bit oe", !v[0], oe[p]);
    end
    apb(1'b1, IDX_MULTI, 32'h0000_000F);
    repeat (6) @(posedge sys_clk);
    h0 = hits;
    ext[18] <= 1'b0;
    ext[16] <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk("irq pin fall", 101, hits - h0);
    ext <= '1;
    repeat (6) @(posedge sys_clk);
    h0 = hits;
    apb(1'b1, IDX_MULTI, 32'h0000_000A);
    repeat (10) @(posedge sys_clk);
    chk("irq latch fall", 101, hits - h0);
    apb(1'b1, IDX_SERIAL, 32'h0000_0007);
    serial_enable <= 1'b1;
    serial_drive <= 3'h2;
    repeat (4) @(posedge sys_clk);
    chk("serial oe", 3'h5, oe[22:20]);
    apb(1'b1, 6'h22, 32'h0000_0000);
    chk("slverr", 1, err);
    give_verdict();
  end
endmodule
